// [rtl/pfc_pkg.sv]
// What this block does
// - host loads every byte of a modified page; unloaded bytes become undefined.
// - host starts each next byte load within 150 us of the previous rise.
// - host keeps the same page number at every falling strobe of one page.
// - with the guard on, host starts each page with the three unlock loads.
package pfc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 50;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_NS = 200;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_WINDOW_NS = 150000;
  localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_NS / CLK_NS;
  localparam int WIN_MARGIN_CYC = 8;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_WDATA = 5'h08;
  localparam logic [4:0] OFS_RDATA = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SEL_LSB = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_WIN = 1;
  localparam int ST_PAGE_ERR = 2;
  localparam int ST_POLL_TO = 3;
  localparam int ST_POLL_OK = 4;
  localparam logic [14:0] RST_ADDR = 15'h0000;
  localparam logic [7:0] RST_WDATA = 8'h00;
  localparam int PAGE_LSB = 6;
  localparam int COMPL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_LOAD = 2'h1;
  localparam logic [1:0] OP_SEQ = 2'h2;
  localparam logic [1:0] OP_POLL = 2'h3;
  localparam logic [1:0] SEL_ENABLE = 2'h0;
  localparam logic [1:0] SEL_DISABLE = 2'h1;
  localparam logic [1:0] SEL_ERASE = 2'h2;
  localparam logic [2:0] LEN_SHORT = 3'h3;
  localparam logic [2:0] LEN_LONG = 3'h6;

  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_WIN, S_RD_ACC, S_RD_GAP, S_WR_SETUP, S_WR_LOW, S_WR_HOLD
  } pfc_state_type;
endpackage

// [rtl/pfc_window_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module pfc_window_timer
  import pfc_pkg::*;
#(
  parameter int LIMIT_CYC = LOAD_WINDOW_CYC - WIN_MARGIN_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // rising strobe of a byte load
  input wire logic rearm_i,
  // window still safely open
  output logic open_o
);
  localparam int CW = $clog2(LIMIT_CYC + 1);
  logic [CW-1:0] cnt;

  if (LIMIT_CYC < 1)
  begin : g_chk
    $error("load window limit too small");
  end

  // the margin keeps the next falling strobe inside the device window
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= '0;
    else if (rearm_i)
      cnt <= CW'(LIMIT_CYC);
    else if (cnt != '0)
      cnt <= cnt - 1'b1;
  end

  assign open_o = (cnt != '0);
endmodule
`default_nettype wire

// [rtl/pfc_ctrl.sv]
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module pfc_ctrl
  import pfc_pkg::*;
#(
  parameter int POLL_MAX = 1000,
  parameter logic [3*23-1:0] SEQ_ENABLE = {15'h0111, 8'h11, 15'h0222, 8'h22, 15'h0333, 8'h33},
  parameter logic [6*23-1:0] SEQ_DISABLE = {15'h0111, 8'h11, 15'h0222, 8'h22, 15'h0333, 8'h44,
                                            15'h0111, 8'h11, 15'h0222, 8'h22, 15'h0333, 8'h55},
  parameter logic [6*23-1:0] SEQ_ERASE = {15'h0111, 8'h11, 15'h0222, 8'h22, 15'h0333, 8'h66,
                                          15'h0111, 8'h11, 15'h0222, 8'h22, 15'h0333, 8'h77}
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash pins
  output logic [14:0] addr_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o
);
  // ****************************************
  // elaboration checks and helpers
  // ****************************************
  if (POLL_MAX < 2 || POLL_MAX > 65535 || LOAD_WINDOW_CYC <= WIN_MARGIN_CYC)
  begin : g_chk
    $error("pfc_ctrl parameters out of range");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // sequence items are stored first-to-last from the top bits down
  function automatic logic [22:0] seq_item(input logic [1:0] sel, input logic [2:0] idx);
    logic [22:0] r;
    r = '0;
    case (sel)
      SEL_ENABLE: r = SEQ_ENABLE[23*(2-idx) +: 23];
      SEL_DISABLE: r = SEQ_DISABLE[23*(5-idx) +: 23];
      default: r = SEQ_ERASE[23*(5-idx) +: 23];
    endcase
    return r;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  pfc_state_type state, next_state;
  logic [14:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata;
  logic [1:0] op_r, sel_r;
  logic [2:0] seq_idx, seq_len;
  logic [22:0] cur;
  logic [3:0] cnt;
  logic [8:0] page;
  logic page_valid;
  logic page_err, poll_to, poll_ok;
  logic prev_tog, have_prev;
  logic [15:0] poll_n;
  logic win_open, rearm;
  logic bus_wr, wr_cmd, wr_status, go, page_bad, poll_hit, poll_last;

  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_cmd = bus_wr && wb_adr_i == OFS_CMD && wb_sel_i[0];
  assign wr_status = bus_wr && wb_adr_i == OFS_STATUS;
  // a reserved sequence select is ignored, as is any command while busy
  assign go = wr_cmd && state == S_IDLE &&
              !(wb_dat_i[CMD_OP_LSB +: 2] == OP_SEQ && wb_dat_i[CMD_SEL_LSB +: 2] == 2'h3);
  assign page_bad = win_open && page_valid && addr_r[14:PAGE_LSB] != page;
  assign poll_hit = have_prev && rdata[TOGGLE_BIT] == prev_tog &&
                    rdata[COMPL_BIT] == wdata_r[COMPL_BIT];
  assign poll_last = poll_n == 16'(POLL_MAX - 1);
  assign rearm = state == S_WR_LOW && next_state == S_WR_HOLD;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_r <= RST_ADDR;
      wdata_r <= RST_WDATA;
    end
    else if (bus_wr && wb_adr_i == OFS_ADDR)
      addr_r <= 15'(merge({17'h0, addr_r}, wb_dat_i, wb_sel_i));
    else if (bus_wr && wb_adr_i == OFS_WDATA)
      wdata_r <= 8'(merge({24'h0, wdata_r}, wb_dat_i, wb_sel_i));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      case (wb_adr_i)
        OFS_ADDR: wb_dat_o <= {17'h0, addr_r};
        OFS_WDATA: wb_dat_o <= {24'h0, wdata_r};
        OFS_RDATA: wb_dat_o <= {24'h0, rdata};
        OFS_STATUS: wb_dat_o <= {27'h0, poll_ok, poll_to, page_err, win_open,
                                 state != S_IDLE};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
  end

  // ****************************************
  // sticky flags, set wins over clear
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      page_err <= 1'b0;
      poll_to <= 1'b0;
      poll_ok <= 1'b0;
    end
    else
    begin
      page_err <= (go && wb_dat_i[CMD_OP_LSB +: 2] == OP_LOAD && page_bad) ||
                  (page_err && !(wr_status && wb_dat_i[ST_PAGE_ERR]));
      poll_to <= (state == S_RD_GAP && op_r == OP_POLL && !poll_hit && poll_last) ||
                 (poll_to && !(wr_status && wb_dat_i[ST_POLL_TO]));
      poll_ok <= (state == S_RD_GAP && op_r == OP_POLL && poll_hit) ||
                 (poll_ok && !(wr_status && wb_dat_i[ST_POLL_OK]));
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (go)
          case (wb_dat_i[CMD_OP_LSB +: 2])
            OP_READ: next_state = S_RD_ACC;
            OP_POLL: next_state = S_WAIT_WIN;
            OP_LOAD: next_state = page_bad ? S_IDLE : S_WR_SETUP;
            default: next_state = S_WR_SETUP;
          endcase
      S_WAIT_WIN:
        if (!win_open)
          next_state = S_RD_ACC;
      S_RD_ACC:
        if (cnt == 4'h0)
          next_state = S_RD_GAP;
      S_RD_GAP:
        next_state = (op_r == OP_POLL && !poll_hit && !poll_last) ? S_RD_ACC : S_IDLE;
      S_WR_SETUP:
        next_state = S_WR_LOW;
      S_WR_LOW:
        if (cnt == 4'h0)
          next_state = S_WR_HOLD;
      S_WR_HOLD:
        next_state = (seq_idx + 3'h1 < seq_len) ? S_WR_SETUP : S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= 4'h0;
    else if (state != S_RD_ACC && next_state == S_RD_ACC)
      cnt <= 4'(ACCESS_CYC - 1);
    else if (state != S_WR_LOW && next_state == S_WR_LOW)
      cnt <= 4'(STROBE_CYC - 1);
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end

  // step and command registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_r <= OP_READ;
      sel_r <= SEL_ENABLE;
      seq_idx <= 3'h0;
      seq_len <= 3'h1;
      cur <= '0;
    end
    else if (go)
    begin
      op_r <= wb_dat_i[CMD_OP_LSB +: 2];
      sel_r <= wb_dat_i[CMD_SEL_LSB +: 2];
      seq_idx <= 3'h0;
      if (wb_dat_i[CMD_OP_LSB +: 2] == OP_SEQ)
      begin
        seq_len <= (wb_dat_i[CMD_SEL_LSB +: 2] == SEL_ENABLE) ? LEN_SHORT : LEN_LONG;
        cur <= seq_item(wb_dat_i[CMD_SEL_LSB +: 2], 3'h0);
      end
      else
      begin
        seq_len <= 3'h1;
        cur <= {addr_r, wdata_r};
      end
    end
    else if (state == S_WR_HOLD && next_state == S_WR_SETUP)
    begin
      seq_idx <= seq_idx + 3'h1;
      cur <= seq_item(sel_r, seq_idx + 3'h1);
    end
  end

  // page of the open load window; unlock loads may target any page
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      page <= 9'h000;
      page_valid <= 1'b0;
    end
    else if (rearm && op_r == OP_LOAD)
    begin
      page <= cur[22:8+PAGE_LSB];
      page_valid <= 1'b1;
    end
    else if (!win_open)
      page_valid <= 1'b0;
  end

  // read capture and poll history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata <= 8'h00;
      prev_tog <= 1'b0;
      have_prev <= 1'b0;
      poll_n <= 16'h0000;
    end
    else if (go)
    begin
      have_prev <= 1'b0;
      poll_n <= 16'h0000;
    end
    else if (state == S_RD_ACC && cnt == 4'h0)
      rdata <= data_i;
    else if (state == S_RD_GAP)
    begin
      prev_tog <= rdata[TOGGLE_BIT];
      have_prev <= 1'b1;
      poll_n <= poll_n + 16'h0001;
    end
  end

  // ****************************************
  // pins: strobes registered from the next state, address and data taken from cur
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      data_oe_n_o <= 1'b1;
    end
    else
    begin
      ce_n_o <= !(next_state inside {S_RD_ACC, S_WR_SETUP, S_WR_LOW, S_WR_HOLD});
      oe_n_o <= !(next_state == S_RD_ACC);
      we_n_o <= !(next_state == S_WR_LOW);
      data_oe_n_o <= !(next_state inside {S_WR_SETUP, S_WR_LOW, S_WR_HOLD});
    end
  end

  assign addr_o = cur[22:8];
  assign data_o = cur[7:0];

  pfc_window_timer #(
    .LIMIT_CYC(LOAD_WINDOW_CYC - WIN_MARGIN_CYC)
  ) u_win (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rearm_i(rearm),
    .open_o(win_open)
  );

  // ****************************************
  // assertions
  // ****************************************
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_no_contention: assert property (!oe_n_o |-> data_oe_n_o)
    else $error("data driven while output enable low");
  a_write_inhibit: assert property (!we_n_o |-> oe_n_o && !ce_n_o)
    else $error("strobe low without chip enable or with output enable");
  a_strobe_width: assert property ($fell(we_n_o) |-> !we_n_o ##1 !we_n_o ##1 we_n_o)
    else $error("strobe low pulse not two cycles");
  // address and data may step between sequence items, but never while the strobe is low
  a_addr_steady: assert property (!we_n_o |-> $stable(addr_o) && $stable(data_o))
    else $error("address moved during load");
  a_data_held: assert property ($rose(we_n_o) |-> !data_oe_n_o && $stable(data_o))
    else $error("data not held at rising strobe");
  a_read_length: assert property ($fell(oe_n_o) |-> (!oe_n_o)[*4] ##1 oe_n_o)
    else $error("read access not four cycles");
  a_window_rearm: assert property ($rose(we_n_o) |-> win_open)
    else $error("window not rearmed by load");
  a_same_page: assert property ($fell(we_n_o) && op_r == OP_LOAD && page_valid
                                |-> addr_o[14:PAGE_LSB] == page)
    else $error("page changed inside load window");
  a_poll_after_win: assert property ($fell(oe_n_o) && op_r == OP_POLL |-> !win_open)
    else $error("poll read inside load window");
  a_poll_ok_cause: assert property ($rose(poll_ok) |-> $past(rdata[TOGGLE_BIT]) == $past(prev_tog)
                                    && $past(have_prev))
    else $error("poll done without steady toggle bit");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");

  c_read: cover property (state == S_RD_GAP && op_r == OP_READ);
  c_load: cover property ($rose(we_n_o) && op_r == OP_LOAD);
  c_seq_done: cover property (state == S_WR_HOLD && seq_idx == 3'h5);
  c_poll_ok: cover property ($rose(poll_ok));
endmodule
`default_nettype wire

// [sim/pfc_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter int WIN_CYC = 2950,
  parameter int WC_CYC = 400,
  // command codes are free choices; a shared prefix keeps them short
  parameter logic [60:0] PRE = {15'h0111, 8'h11, 15'h0222, 8'h22, 15'h0333},
  parameter logic [68:0] SEQ_ON = {PRE, 8'h33},
  parameter logic [137:0] SEQ_OFF = {PRE, 8'h44, PRE, 8'h55},
  parameter logic [137:0] SEQ_ERA = {PRE, 8'h66, PRE, 8'h77}
) (
  // timer clock
  input wire logic clk_i,
  // strobes, active low
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  // address and data wire
  input wire logic [14:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_en_o
);
  // ****************************************
  // array, load window, write guard
  // ****************************************
  logic [7:0] mem [32768];
  logic [22:0] q [$];
  logic [14:0] la;
  logic [7:0] last = 8'h00;
  logic [7:0] idle = 8'h5A;
  logic ld = 1'b0;
  logic guard = 1'b0;
  logic tog = 1'b0;
  logic rearm = 1'b0;
  logic open_w = 1'b0;
  int win = 0;
  int busy = 0;
  realtime t_fall;
  initial
    foreach (mem[i])
      mem[i] = 8'hFF;
  function automatic bit hit(input logic [137:0] s, input int n);
    hit = q.size() >= n;
    for (int i = 0; i < n && hit; i++)
      hit = (q[i] === s[(n - 1 - i) * 23 +: 23]);
  endfunction
  task automatic commit(input int from);
    logic [63:0] got;
    logic [8:0] pg;
    got = '0;
    pg = q[from][22:14];
    foreach (q[i])
      if (i >= from)
      begin
        mem[q[i][22:8]] = q[i][7:0];
        got[q[i][13:8]] = 1'b1;
      end
    for (int b = 0; b < 64; b++)
      if (!got[b])
        mem[{pg, b[5:0]}] = ~mem[{pg, b[5:0]}];
  endtask
  task automatic close_window();
    busy = WC_CYC;
    if (q.size() == 6 && hit(SEQ_OFF, 6))
      guard = 1'b0;
    else if (q.size() == 6 && hit(SEQ_ERA, 6))
      foreach (mem[i])
        mem[i] = 8'hFF;
    else if (hit(SEQ_ON, 3))
    begin
      guard = 1'b1;
      if (q.size() > 3)
        commit(3);
    end
    else if (!guard)
      commit(0);
    q.delete();
  endtask
  always @(negedge ce_n_i or negedge we_n_i)
    if (!ce_n_i && !we_n_i && oe_n_i && busy == 0)
    begin
      la = addr_i;
      ld = 1'b1;
      t_fall = $realtime;
    end
  always @(posedge ce_n_i or posedge we_n_i)
    if (ld)
    begin
      ld = 1'b0;
      // short glitches never reach the page buffer
      if ($realtime - t_fall >= 15.0)
      begin
        q.push_back({la, data_i});
        last = data_i;
        rearm = 1'b1;
      end
    end
  // timers step on the falling edge so read data never changes at the controller's sample edge
  always @(negedge clk_i)
  begin
    idle <= ~idle;
    if (busy > 0)
      busy = busy - 1;
    if (rearm)
    begin
      rearm = 1'b0;
      win = 0;
      open_w = 1'b1;
    end
    else if (open_w && win >= WIN_CYC - 1)
    begin
      open_w = 1'b0;
      close_window();
    end
    else
      win = win + 1;
  end
  // end of a read, seen once even when both enables rise in the same step
  always @(negedge data_en_o)
    if (busy > 0)
      tog = ~tog;
  assign data_en_o = !ce_n_i && !oe_n_i && we_n_i;
  assign data_o = data_en_o ? (busy > 0 ? {~last[7], tog, last[5:0]} : mem[addr_i]) : idle;
endmodule
`default_nettype wire

// [sim/pfc_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module pfc_ctrl_tb
  import pfc_pkg::*;
  ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rv;
  logic ack, ce_n, oe_n, we_n, doe_n, fm_en;
  logic [14:0] fa;
  logic [7:0] d_o, fm_q, bus;
  logic [15:0] lf = 16'h0015;
  logic [8:0] p1, p2, p3;
  int errors = 0;
  int check_count = 0;
  int cyc_n = 0;
  int exp_m [32768];
  assign bus = !doe_n ? d_o : fm_q;
  always #25 clk_i = ~clk_i;
  pfc_ctrl #(.POLL_MAX(150)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .addr_o(fa), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .data_i(bus),
    .data_o(d_o), .data_oe_n_o(doe_n));
  pfc_flash_model fm (.clk_i(clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa),
    .data_i(bus), .data_o(fm_q), .data_en_o(fm_en));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic print_verdict();
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c);
    xfer(1'b1, OFS_CMD, {28'h0, c});
    do
      xfer(1'b0, OFS_STATUS, 32'h0);
    while (rv[ST_BUSY] !== 1'b0);
  endtask
  // upper random bits must be ignored by the controller
  task automatic load(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b1, OFS_ADDR, {lf, 1'b0, a});
    xfer(1'b1, OFS_WDATA, {lf, 8'h00, d});
    cmd({SEL_ENABLE, OP_LOAD});
  endtask
  task automatic rd(input logic [14:0] a);
    xfer(1'b1, OFS_ADDR, {17'h0, a});
    cmd({SEL_ENABLE, OP_READ});
    xfer(1'b0, OFS_RDATA, 32'h0);
    chk("flash byte", exp_m[a], rv);
  endtask
  task automatic fin(input logic [14:0] a, input logic bad, input logic [4:0] st);
    xfer(1'b1, OFS_ADDR, {17'h0, a});
    xfer(1'b1, OFS_WDATA, {24'h0, exp_m[a][7:0] ^ {bad, 7'h00}});
    cmd({SEL_ENABLE, OP_POLL});
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk("status", {27'h0, st}, rv);
    xfer(1'b1, OFS_STATUS, 32'h1C);
  endtask
  // odd stride visits every byte once, out of order, loads back to back;
  // the last load lands on byte 0, the byte that the poll reads back
  task automatic page(input logic [8:0] p, input logic upd);
    logic [5:0] j;
    for (int i = 0; i < 64; i++)
    begin
      j = 6'((i + 1) * 37);
      lf = step(lf);
      load({p, j}, lf[7:0]);
      if (upd)
        exp_m[{p, j}] = lf[7:0];
    end
  endtask
  task automatic spot(input logic [8:0] p);
    repeat (3)
    begin
      lf = step(lf);
      rd({p, lf[5:0]});
    end
  endtask
  always @(posedge clk_i)
    if (doe_n === 1'b0 && fm_en === 1'b1)
      chk("bus clash", 32'h0, 32'h1);
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 80000)
    begin
      errors++;
      print_verdict();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    foreach (exp_m[i])
      exp_m[i] = 255;
    lf = step(lf);
    p1 = lf[8:0];
    p2 = p1 ^ 9'h001;
    p3 = p1 ^ 9'h002;
    repeat (12)
      @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
      if (i != 3)
      begin
        xfer(1'b0, 5'(i * 4), 32'h0);
        chk("reset reg", 32'h0, rv);
      end
    rd({p1, 6'h3F});
    page(p1, 1'b1);
    fin({p1, 6'h00}, 1'b0, 5'h10);
    spot(p1);
    page(p2, 1'b1);
    fin({p2, 6'h00}, 1'b1, 5'h08);
    spot(p2);
    load({p1, 6'h05}, 8'hA5);
    load({p2, 6'h05}, 8'h5A);
    exp_m[{p1, 6'h05}] = 8'hA5;
    fin({p1, 6'h05}, 1'b0, 5'h14);
    rd({p2, 6'h05});
    cmd({SEL_ENABLE, OP_SEQ});
    fin({p3, 6'h00}, 1'b0, 5'h10);
    page(p3, 1'b0);
    fin({p3, 6'h00}, 1'b0, 5'h10);
    spot(p3);
    cmd({SEL_ENABLE, OP_SEQ});
    page(p3, 1'b1);
    fin({p3, 6'h00}, 1'b0, 5'h10);
    spot(p3);
    cmd({SEL_DISABLE, OP_SEQ});
    fin({p3, 6'h00}, 1'b0, 5'h10);
    page(p2, 1'b1);
    fin({p2, 6'h00}, 1'b0, 5'h10);
    spot(p2);
    cmd({SEL_ERASE, OP_SEQ});
    foreach (exp_m[i])
      exp_m[i] = 255;
    fin({p3, 6'h00}, 1'b0, 5'h10);
    spot(p3);
    spot(p2);
    xfer(1'b1, OFS_CMD, {28'h0, 2'h3, OP_SEQ});
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h0, rv);
    print_verdict();
  end
endmodule
`default_nettype wire
